// ---- inc/es_consts.svh ----
// Constants of the encoder fault supervisor: timing, register map, codes.
// Assumes a 200 MHz core clock; included by the package and the design.
`ifndef ES_CONSTS_SVH
`define ES_CONSTS_SVH

`define ES_CLK_MHZ 200
`define ES_WIN_US 1000
`define ES_OC_NS 10000
`define ES_OC_CYC ((`ES_OC_NS * `ES_CLK_MHZ + 999) / 1000)
`define ES_WARN_WIN 3
`define ES_ESC_WIN 100

`define ES_OFS_CTRL 8'h00
`define ES_OFS_DEVTOL 8'h04
`define ES_OFS_STILL 8'h08
`define ES_OFS_STATUS 8'h0C
`define ES_OFS_MSG 8'h10

`define ES_RST_OCEN 1'h1
`define ES_RST_DEVTOL 16'h0010
`define ES_RST_STILL 16'h0002

`define ES_MSG_NONE 16'h0000
`define ES_MSG_OPEN 16'h0001
`define ES_MSG_DEV 16'h0002
`define ES_MSG_E6000 16'h1770

`define ES_RESP_OKAY 2'h0
`define ES_RESP_SLVERR 2'h2

`endif

// ---- inc/es_pkg.sv ----
// Types of the encoder fault supervisor.
// Assumes es_consts.svh on the include path.
`include "es_consts.svh"
package es_pkg;

  typedef enum logic [2:0] {
    ES_F_OK = 3'h1,
    ES_F_WARN = 3'h2,
    ES_F_ERR = 3'h4
  } es_fstate_t;

  typedef struct packed {
    logic [5:0] enc1;
    logic [5:0] enc2;
    logic [1:0] prox1;
    logic [1:0] prox2;
    logic [1:0] prox_prev;
    logic rst1;
    logic rst2;
    logic rst_prev;
    logic [2:0][11:0] oc_cnt;
    logic [2:0] oc;
    logic [17:0] win_cnt;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [1:0] dev_run;
    logic [15:0] esc_cnt;
    es_fstate_t fst;
    logic blocked;
    logic led;
    logic outs_on;
    logic range_force;
    logic [15:0] msg;
    logic oc_en;
    logic [15:0] dev_tol;
    logic [15:0] still_min;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } es_state_t;

endpackage

// ---- verilog/es_supervisor.sv ----
// Encoder fault supervisor: open-circuit and proximity-switch deviation checks.
// Assumes AXI4-Lite master on CORE_CLK; encoder and switch pins are asynchronous.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "es_consts.svh"

// Function
// - Open circuit lights fault LED, switches outputs off, shows open-circuit message.
// - Open-circuit message is refreshed every cycle while the fault lasts.
// - After open circuit clears, outputs stay off until start-up conditions hold.
// - Open circuit flagged when any complementary pair A, B or Z is implausible.
// - Lasting switch frequency mismatch lights fault LED and raises deviation warning.
// - Warning and LED clear by themselves once both switches give valid signals.
// - During the warning, range monitoring is suspended and treated as violated.
// - Mismatch persisting without valid signals raises error 6000, outputs off, LED on.
// - Error 6000 clears on valid signals or a falling edge at restart input.
// - After error 6000 clears, outputs stay off until start-up conditions hold.
module es_supervisor
  import es_pkg::*;
#(
  parameter int WIN_CYC = `ES_WIN_US * `ES_CLK_MHZ,
  parameter int ESC_WIN = `ES_ESC_WIN
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Encoder tracks, complementary pairs
  input wire logic ENC_A,
  input wire logic ENC_A_N,
  input wire logic ENC_B,
  input wire logic ENC_B_N,
  input wire logic ENC_Z,
  input wire logic ENC_Z_N,
  // Proximity switches and restart terminal
  input wire logic PROX_A,
  input wire logic PROX_B,
  input wire logic RESTART_INPUT_TERMINAL,
  // Start-up conditions from the start logic
  input wire logic START_COND_MET,
  // Supervision results
  output logic FAULT_LED,
  output logic OUTPUTS_ON,
  output logic RANGE_FORCE,
  output logic [15:0] MSG_CODE,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  es_state_t s_q;
  es_state_t s_d;

  logic [1:0] rise;
  logic rst_fall;
  logic win_end;
  logic [15:0] diff;
  logic dev;
  logic both_valid;
  logic fault_d;
  logic [4:0] widx;

  // Word index of a mapped register, or all ones when unmapped
  function automatic logic [4:0] es_dec(input logic [7:0] a);
    case (a)
      `ES_OFS_CTRL: es_dec = 5'h00;
      `ES_OFS_DEVTOL: es_dec = 5'h01;
      `ES_OFS_STILL: es_dec = 5'h02;
      `ES_OFS_STATUS: es_dec = 5'h03;
      `ES_OFS_MSG: es_dec = 5'h04;
      default: es_dec = 5'h1F;
    endcase
  endfunction
  function automatic logic [15:0] es_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] st);
    es_merge = old;
    if (st[0])
      es_merge[7:0] = d[7:0];
    if (st[1])
      es_merge[15:8] = d[15:8];
  endfunction

  always_comb
  begin
    s_d = s_q;
    // Two-stage synchronisers for the encoder, switch and restart pins
    s_d.enc1 = {ENC_Z_N, ENC_Z, ENC_B_N, ENC_B, ENC_A_N, ENC_A};
    s_d.enc2 = s_q.enc1;
    s_d.prox1 = {PROX_B, PROX_A};
    s_d.prox2 = s_q.prox1;
    s_d.prox_prev = s_q.prox2;
    s_d.rst1 = RESTART_INPUT_TERMINAL;
    s_d.rst2 = s_q.rst1;
    s_d.rst_prev = s_q.rst2;
    rise = s_q.prox2 & ~s_q.prox_prev;
    rst_fall = s_q.rst_prev & ~s_q.rst2;

    // Pair with equal levels on both wires for the debounce time is open
    for (int i = 0; i < 3; i++)
    begin
      if (s_q.oc_en && (s_q.enc2[2*i] == s_q.enc2[2*i+1]))
      begin
        if (s_q.oc_cnt[i] != 12'(`ES_OC_CYC))
          s_d.oc_cnt[i] = s_q.oc_cnt[i] + 12'h001;
      end
      else
        s_d.oc_cnt[i] = 12'h000;
      s_d.oc[i] = (s_d.oc_cnt[i] == 12'(`ES_OC_CYC));
    end

    // Edge counts per window compare the two switch frequencies
    win_end = (s_q.win_cnt == 18'(WIN_CYC - 1));
    s_d.win_cnt = win_end ? 18'h0_0000 : s_q.win_cnt + 18'h0_0001;
    diff = (s_q.cnt_a > s_q.cnt_b) ? s_q.cnt_a - s_q.cnt_b : s_q.cnt_b - s_q.cnt_a;
    dev = (diff > s_q.dev_tol);
    both_valid = !dev && (s_q.cnt_a >= s_q.still_min) && (s_q.cnt_b >= s_q.still_min);
    if (win_end)
    begin
      s_d.cnt_a = {15'h0000, rise[0]};
      s_d.cnt_b = {15'h0000, rise[1]};
    end
    else
    begin
      if (rise[0] && s_q.cnt_a != 16'hFFFF)
        s_d.cnt_a = s_q.cnt_a + 16'h0001;
      if (rise[1] && s_q.cnt_b != 16'hFFFF)
        s_d.cnt_b = s_q.cnt_b + 16'h0001;
    end

    case (s_q.fst)
      ES_F_OK:
      begin
        if (win_end)
        begin
          if (!dev)
            s_d.dev_run = 2'h0;
          else if (s_q.dev_run == 2'(`ES_WARN_WIN - 1))
          begin
            s_d.fst = ES_F_WARN;
            s_d.esc_cnt = 16'h0000;
            s_d.dev_run = 2'h0;
          end
          else
            s_d.dev_run = s_q.dev_run + 2'h1;
        end
      end
      ES_F_WARN:
      begin
        if (win_end)
        begin
          if (both_valid)
            s_d.fst = ES_F_OK;
          else if (s_q.esc_cnt == 16'(ESC_WIN - 1))
            s_d.fst = ES_F_ERR;
          else
            s_d.esc_cnt = s_q.esc_cnt + 16'h0001;
        end
      end
      ES_F_ERR:
      begin
        if (rst_fall || (win_end && both_valid))
          s_d.fst = ES_F_OK;
      end
      default:
        s_d.fst = ES_F_OK;
    endcase

    // Outputs need start-up conditions again after any shutdown fault
    fault_d = (|s_d.oc) || (s_d.fst == ES_F_ERR);
    if (fault_d)
      s_d.blocked = 1'h1;
    else if (START_COND_MET)
      s_d.blocked = 1'h0;
    s_d.outs_on = !fault_d && !s_d.blocked && START_COND_MET;
    s_d.led = (|s_d.oc) || (s_d.fst != ES_F_OK);
    s_d.range_force = (s_d.fst == ES_F_WARN);
    // Message rebuilt every cycle so it tracks the live condition
    if (|s_d.oc)
      s_d.msg = `ES_MSG_OPEN;
    else if (s_d.fst == ES_F_ERR)
      s_d.msg = `ES_MSG_E6000;
    else if (s_d.fst == ES_F_WARN)
      s_d.msg = `ES_MSG_DEV;
    else
      s_d.msg = `ES_MSG_NONE;

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && s_q.awready)
    begin
      s_d.aw_have = 1'h1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_q.wready)
    begin
      s_d.w_have = 1'h1;
      s_d.w_data = S_AXI_WDATA;
      s_d.w_strb = S_AXI_WSTRB;
    end
    if (s_q.bvalid && S_AXI_BREADY)
      s_d.bvalid = 1'h0;
    widx = es_dec(s_q.aw_addr);
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'h0;
      s_d.w_have = 1'h0;
      s_d.bvalid = 1'h1;
      s_d.bresp = `ES_RESP_OKAY;
      case (widx)
        5'h00:
        begin
          if (s_q.w_strb[0])
            s_d.oc_en = s_q.w_data[0];
        end
        5'h01: s_d.dev_tol = es_merge(s_q.dev_tol, s_q.w_data, s_q.w_strb);
        5'h02: s_d.still_min = es_merge(s_q.still_min, s_q.w_data, s_q.w_strb);
        5'h03, 5'h04: s_d.bresp = `ES_RESP_OKAY;
        default: s_d.bresp = `ES_RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && S_AXI_RREADY)
      s_d.rvalid = 1'h0;
    if (S_AXI_ARVALID && s_q.arready)
    begin
      s_d.rvalid = 1'h1;
      s_d.rresp = `ES_RESP_OKAY;
      case (es_dec(S_AXI_ARADDR))
        5'h00: s_d.rdata = {31'h0000_0000, s_q.oc_en};
        5'h01: s_d.rdata = {16'h0000, s_q.dev_tol};
        5'h02: s_d.rdata = {16'h0000, s_q.still_min};
        5'h03: s_d.rdata = {24'h00_0000, s_q.outs_on, s_q.blocked, s_q.fst, s_q.oc};
        5'h04: s_d.rdata = {16'h0000, s_q.msg};
        default:
        begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `ES_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      s_q <= '0;
      s_q.fst <= ES_F_OK;
      s_q.blocked <= 1'h1;
      s_q.oc_en <= `ES_RST_OCEN;
      s_q.dev_tol <= `ES_RST_DEVTOL;
      s_q.still_min <= `ES_RST_STILL;
    end
    else
      s_q <= s_d;
  end

  assign FAULT_LED = s_q.led;
  assign OUTPUTS_ON = s_q.outs_on;
  assign RANGE_FORCE = s_q.range_force;
  assign MSG_CODE = s_q.msg;
  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY = s_q.wready;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RRESP = s_q.rresp;
  assign S_AXI_RDATA = s_q.rdata;

  property p_oc_off;
    @(posedge CORE_CLK) disable iff (RESET) (|s_q.oc) |-> (FAULT_LED && !OUTPUTS_ON);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("open circuit left outputs on");
  property p_oc_msg;
    @(posedge CORE_CLK) disable iff (RESET) (|s_q.oc) |-> (MSG_CODE == `ES_MSG_OPEN);
  endproperty
  a_oc_msg: assert property (p_oc_msg) else $error("open circuit message missing");
  property p_oc_hold;
    @(posedge CORE_CLK) disable iff (RESET) ($fell(|s_q.oc) && !$past(START_COND_MET))
      |-> !OUTPUTS_ON;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("outputs back without start");
  property p_oc_cnt;
    @(posedge CORE_CLK) disable iff (RESET)
      (s_q.oc != 3'h0) |-> $past(s_q.oc_en) && s_q.oc_en;
  endproperty
  a_oc_cnt: assert property (p_oc_cnt) else $error("open circuit without check");
  property p_warn;
    @(posedge CORE_CLK) disable iff (RESET)
      (s_q.fst == ES_F_WARN && s_q.oc == 3'h0) |-> (FAULT_LED && MSG_CODE == `ES_MSG_DEV);
  endproperty
  a_warn: assert property (p_warn) else $error("deviation warning not shown");
  property p_warn_clr;
    @(posedge CORE_CLK) disable iff (RESET)
      (s_q.fst == ES_F_WARN && win_end && both_valid) |=> (s_q.fst == ES_F_OK && !RANGE_FORCE);
  endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning did not clear");
  property p_range;
    @(posedge CORE_CLK) disable iff (RESET) (s_q.fst == ES_F_WARN) |-> RANGE_FORCE;
  endproperty
  a_range: assert property (p_range) else $error("range not forced during warning");
  property p_err;
    @(posedge CORE_CLK) disable iff (RESET) (s_q.fst == ES_F_ERR)
      |-> (!OUTPUTS_ON && FAULT_LED && (MSG_CODE == `ES_MSG_E6000 || s_q.oc != 3'h0));
  endproperty
  a_err: assert property (p_err) else $error("error 6000 not enforced");
  property p_restart;
    @(posedge CORE_CLK) disable iff (RESET) (s_q.fst == ES_F_ERR && rst_fall)
      |=> (s_q.fst == ES_F_OK);
  endproperty
  a_restart: assert property (p_restart) else $error("restart edge ignored");
  property p_err_hold;
    @(posedge CORE_CLK) disable iff (RESET)
      ($past(s_q.fst) == ES_F_ERR && s_q.fst == ES_F_OK && !$past(START_COND_MET))
      |-> !OUTPUTS_ON;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("outputs on after 6000");

endmodule

// ---- bench/es_far_model.sv ----
// Far-side model: quadrature encoder and two proximity switches.
// Assumes the bench clock; the bench sets open pairs and switch rates.
`timescale 1ns/1ps
module es_far_model #(
  parameter int STEP = 3
)
(
  // Clock
  input wire logic clk,
  // Open pairs (bit0 A) and switch half periods, zero stands still
  input wire logic [2:0] open_pair,
  input wire logic [7:0] half_a,
  input wire logic [7:0] half_b,
  // Tracks {Z_N,Z,B_N,B,A_N,A}
  output logic [5:0] enc,
  // Switch levels {B,A}
  output logic [1:0] prox
);
  logic [7:0] div = 8'h00;
  logic [5:0] pos = 6'h00;
  logic [1:0][7:0] cnt = '0;
  logic [1:0] lvl = 2'h0;
  logic [1:0][7:0] half;
  logic a, b, z;
  assign half = {half_b, half_a};
  always_ff @(posedge clk)
  begin
    div <= (div == 8'(STEP - 1)) ? 8'h00 : div + 8'h01;
    if (div == 8'h00)
      pos <= pos + 6'h01;
    for (int i = 0; i < 2; i++)
    begin
      // A stalled switch holds its level, as a stopped shaft would
      if (half[i] == 8'h00)
        cnt[i] <= 8'h00;
      else if (cnt[i] >= half[i] - 8'h01)
      begin
        cnt[i] <= 8'h00;
        lvl[i] <= ~lvl[i];
      end
      else
        cnt[i] <= cnt[i] + 8'h01;
    end
  end
  // Gray stepping keeps B a quarter period ahead of A
  assign a = pos[1];
  assign b = pos[1] ^ pos[0];
  assign z = (pos == 6'h00);
  // A broken pair shows equal levels on both wires
  assign enc[1:0] = open_pair[0] ? 2'h0 : {~a, a};
  assign enc[3:2] = open_pair[1] ? 2'h0 : {~b, b};
  assign enc[5:4] = open_pair[2] ? 2'h0 : {~z, z};
  assign prox = lvl;
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the encoder fault supervisor.
// Assumes es_consts.svh on the include path; short windows for speed.
`timescale 1ns/1ps
`include "es_consts.svh"
module tb;
  localparam int WIN = 50;
  localparam int ESC = 4;
  logic clk, rst, start_ok, restart;
  logic [2:0] open_pair;
  logic [7:0] half_a, half_b, awaddr, araddr;
  logic [5:0] enc;
  logic [1:0] prox, bresp, rresp;
  logic led, outs_on, rforce;
  logic [15:0] msg;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] pat [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  int n_errors = 0;
  int check_count = 0;

  es_supervisor #(.WIN_CYC(WIN), .ESC_WIN(ESC)) es_supervisor_inst (
    .CORE_CLK(clk), .RESET(rst),
    .ENC_A(enc[0]), .ENC_A_N(enc[1]), .ENC_B(enc[2]),
    .ENC_B_N(enc[3]), .ENC_Z(enc[4]), .ENC_Z_N(enc[5]),
    .PROX_A(prox[0]), .PROX_B(prox[1]),
    .RESTART_INPUT_TERMINAL(restart), .START_COND_MET(start_ok),
    .FAULT_LED(led), .OUTPUTS_ON(outs_on), .RANGE_FORCE(rforce), .MSG_CODE(msg),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  es_far_model es_far_model_inst (
    .clk(clk), .open_pair(open_pair), .half_a(half_a), .half_b(half_b),
    .enc(enc), .prox(prox)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pin_chk(input logic l, input logic [15:0] m);
    chk(32'({led, msg}), 32'({l, m}));
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (!bvalid && n < 200);
    chk(32'({bvalid, bresp}), 32'({1'h1, er}));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'h0;
    end
    while (!rvalid && n < 200);
    chk(32'({rvalid, rresp}), 32'({1'h1, er}));
    chk(rdata & m, e);
  endtask

  // Generous span: the open-circuit debounce dominates the run
  initial
  begin
    step(40000);
    n_errors++;
    finish_test();
  end

  initial
  begin
    rst = 1'h1;
    start_ok = 1'h0;
    restart = 1'h0;
    open_pair = 3'h0;
    half_a = 8'h04;
    half_b = 8'h04;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    step(10);
    rst <= 1'h0;
    step(1);
    rd(`ES_OFS_CTRL, 32'h0000_0001, 32'(`ES_RST_OCEN), `ES_RESP_OKAY);
    rd(`ES_OFS_DEVTOL, 32'h0000_FFFF, 32'(`ES_RST_DEVTOL), `ES_RESP_OKAY);
    rd(`ES_OFS_STILL, 32'h0000_FFFF, 32'(`ES_RST_STILL), `ES_RESP_OKAY);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000, `ES_RESP_SLVERR);
    wr(8'h14, 32'h0000_0001, `ES_RESP_SLVERR);
    wr(`ES_OFS_DEVTOL, 32'h0000_0002, `ES_RESP_OKAY);
    rd(`ES_OFS_DEVTOL, 32'h0000_FFFF, 32'h0000_0002, `ES_RESP_OKAY);
    start_ok <= 1'h1;
    step(3 * WIN);
    pin_chk(1'h0, `ES_MSG_NONE);
    chk(32'(outs_on), 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      start_ok <= 1'h0;
      open_pair <= pat[i];
      step(`ES_OC_CYC + 100);
      pin_chk(1'h1, `ES_MSG_OPEN);
      chk(32'(outs_on), 32'h0000_0000);
      rd(`ES_OFS_STATUS, 32'h0000_0007, 32'(pat[i]), `ES_RESP_OKAY);
      step(500);
      pin_chk(1'h1, `ES_MSG_OPEN);
      open_pair <= 3'h0;
      step(10);
      pin_chk(1'h0, `ES_MSG_NONE);
      chk(32'(outs_on), 32'h0000_0000);
      start_ok <= 1'h1;
      step(3);
      chk(32'(outs_on), 32'h0000_0001);
    end
    wr(`ES_OFS_CTRL, 32'h0000_0000, `ES_RESP_OKAY);
    open_pair <= 3'h7;
    step(`ES_OC_CYC + 100);
    pin_chk(1'h0, `ES_MSG_NONE);
    open_pair <= 3'h0;
    wr(`ES_OFS_CTRL, 32'h0000_0001, `ES_RESP_OKAY);
    half_b <= 8'd20;
    step(240);
    pin_chk(1'h1, `ES_MSG_DEV);
    chk(32'(rforce), 32'h0000_0001);
    rd(`ES_OFS_STATUS, 32'h0000_0038, 32'h0000_0010, `ES_RESP_OKAY);
    half_b <= 8'h04;
    step(150);
    pin_chk(1'h0, `ES_MSG_NONE);
    chk(32'(rforce), 32'h0000_0000);
    half_b <= 8'h00;
    step(600);
    pin_chk(1'h1, `ES_MSG_E6000);
    chk(32'(outs_on), 32'h0000_0000);
    rd(`ES_OFS_STATUS, 32'h0000_00F8, 32'h0000_0060, `ES_RESP_OKAY);
    rd(`ES_OFS_MSG, 32'h0000_FFFF, 32'(`ES_MSG_E6000), `ES_RESP_OKAY);
    start_ok <= 1'h0;
    restart <= 1'h1;
    step(5);
    restart <= 1'h0;
    step(10);
    pin_chk(1'h0, `ES_MSG_NONE);
    chk(32'(outs_on), 32'h0000_0000);
    step(600);
    pin_chk(1'h1, `ES_MSG_E6000);
    half_b <= 8'h04;
    step(150);
    pin_chk(1'h0, `ES_MSG_NONE);
    chk(32'(outs_on), 32'h0000_0000);
    start_ok <= 1'h1;
    step(3);
    chk(32'(outs_on), 32'h0000_0001);
    finish_test();
  end
endmodule
